// ---- hdl/fta_fuse_turn.sv ----
// Fuse configuration access, revolution counter and lock report behind the serial link
`timescale 1ns/1ps
`include "fta_defines.svh"

// Functional notes
// - Volatile-write command 11111 loads config bits into volatile storage, no fuse blown.
// - Zero angle in bits 7..0, gain in 11..9, redundancy selector in 15..12.
// - Config bit 8 set enables polling mode; clear disables it unless selector 1001 forces it high.
// - Burn command 11001 permanently programs only config bits 0..15.
// - Bits 16..45 are factory trim, never changed by write or burn.
// - After a fuse reload, fuse-read 01111 returns full config; a later write replaces bits 0..15, a later burn sets them to all burned bits.
// - Analog read 01001 leaves serial output idle, streams one bit per clock on program pin.
// - Selector 0001..1100 forces bit 0..11; 0000 and 1101..1111 force nothing.
// - Redundancy forces at most one selected bit, only ever high.
// - Eight-bit counter counts up on clockwise, down on counter-clockwise zero crossings.
// - Revolution counter holds zero after reset.
// - Counter is two's complement, -128 to 127, clockwise positive.
// - Counter-clear bit of command 19 clears the counter about three core clocks after that bit's edge, once synchronised.
// - Crossings after the clear still update the counter.
// - Lock reported high when tracker locked, low when unlocked.
// - Counter clear rides in hysteresis/reset command 10011 and zeroes the counter.
// - Lock is the leading bit of angle-read 00000 and counter-read 00001.
// - Fuse-reload bit of the hysteresis/reset command re-reads the fuses.
module fta_fuse_turn
    import fta_pkg::*;
#(
    parameter logic [29:0] TRIM_INIT = 30'h00000000
)
(
    // Core clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Serial link
    input wire logic serial_clock_pin,
    input wire logic chip_select_n,
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_oe_n,
    // Program pin
    input wire logic program_pin_in,
    output logic program_pin_out,
    output logic program_pin_oe_n,
    // Tracking converter
    input wire logic tracker_locked,
    input wire logic [7:0] angle_value,
    input wire logic [5:0] agc_value,
    input wire logic zero_cross_cw,
    input wire logic zero_cross_ccw,
    // Configuration and counter outputs
    output logic [7:0] zero_angle,
    output logic [2:0] gain_setting,
    output logic polling_mode,
    output logic [7:0] revolution_count,
    output logic lock_status,
    output logic config_valid
);

    // ---------------------------------------------------------------
    // Functions
    // ---------------------------------------------------------------
    function automatic logic [15:0] apply_redundancy(input logic [15:0] cust);
        logic [15:0] res;
        logic [3:0] sel;
        res = cust;
        sel = cust[`FTA_RED_MSB:`FTA_RED_LSB];
        if (sel >= `FTA_RED_FIRST && sel <= `FTA_RED_LAST)
        begin
            res[sel - `FTA_RED_FIRST] = 1'b1;
        end
        return res;
    endfunction

    function automatic logic [`FTA_CFG_W-1:0] read_image(input logic [4:0] cmd,
                                                        input fta_snap_t s);
        logic [14:0] body;
        logic [`FTA_CFG_W-1:0] img;
        body = '0;
        img = '0;
        if (cmd == `FTA_CMD_ANGLE_READ)
        begin
            body = {s.lock, s.agc, s.angle};
        end
        else
        begin
            body = {s.lock, s.agc, s.count};
        end
        img[`FTA_CFG_W-1 -: `FTA_RD_W] = {body, ^body};
        if (cmd == `FTA_CMD_FUSE_READ || cmd == `FTA_CMD_ANALOG_READ)
        begin
            img = s.cfg;
        end
        return img;
    endfunction

    // ---------------------------------------------------------------
    // Link side: frame shift and decode
    // ---------------------------------------------------------------
    // Chip select high ends a frame even while the link clock stands still.
    logic frame_rst;
    logic [5:0] bit_cnt_q;
    logic [49:0] shift_q;
    fta_phase_t phase_q;
    logic [`FTA_CFG_W-1:0] out_sr_q;
    logic [4:0] cmd_in;
    logic [`FTA_CFG_W-1:0] img_w;
    logic hold_done_q;
    logic [50:0] hold_q;
    logic clear_tgl_q;
    logic reload_tgl_q;
    logic ack_tgl_q;
    logic req_l;
    fta_snap_t copy_q;
    fta_snap_t snap_q;
    logic req_tgl_q;

    assign frame_rst = srst | chip_select_n;
    assign cmd_in = {shift_q[3:0], serial_data_in};
    assign img_w = read_image(cmd_in, copy_q);

    always_ff @(posedge serial_clock_pin or posedge frame_rst)
    begin
        if (frame_rst)
        begin
            bit_cnt_q <= 6'h00;
            shift_q <= '0;
        end
        else
        begin
            if (bit_cnt_q != 6'h3f)
            begin
                bit_cnt_q <= bit_cnt_q + 6'h01;
            end
            shift_q <= {shift_q[48:0], serial_data_in};
        end
    end

    always_ff @(posedge serial_clock_pin or posedge frame_rst)
    begin
        if (frame_rst)
        begin
            phase_q <= PH_CMD;
            out_sr_q <= '0;
            serial_data_out <= 1'b0;
            serial_data_oe_n <= 1'b1;
            program_pin_out <= 1'b0;
            program_pin_oe_n <= 1'b1;
        end
        else
        begin
            case (phase_q)
                PH_CMD:
                begin
                    if (bit_cnt_q == 6'(`FTA_CMD_W - 1))
                    begin
                        out_sr_q <= img_w;
                        if (cmd_in == `FTA_CMD_ANGLE_READ || cmd_in == `FTA_CMD_COUNT_READ ||
                            cmd_in == `FTA_CMD_FUSE_READ)
                        begin
                            phase_q <= PH_READ;
                            serial_data_out <= img_w[`FTA_CFG_W-1];
                            serial_data_oe_n <= 1'b0;
                        end
                        else if (cmd_in == `FTA_CMD_ANALOG_READ)
                        begin
                            phase_q <= PH_ANALOG;
                            program_pin_out <= copy_q.cfg[`FTA_CFG_W-1];
                            program_pin_oe_n <= 1'b0;
                        end
                        else if (cmd_in == `FTA_CMD_VOL_WRITE || cmd_in == `FTA_CMD_BURN)
                        begin
                            phase_q <= PH_WRITE;
                        end
                        else if (cmd_in == `FTA_CMD_HYST_RESET)
                        begin
                            phase_q <= PH_HYST;
                        end
                        else
                        begin
                            phase_q <= PH_IGNORE;
                        end
                    end
                end
                PH_READ:
                begin
                    out_sr_q <= {out_sr_q[`FTA_CFG_W-2:0], 1'b0};
                    serial_data_out <= out_sr_q[`FTA_CFG_W-2];
                end
                PH_ANALOG:
                begin
                    // One fuse bit per clock, serial output stays released
                    out_sr_q <= {out_sr_q[`FTA_CFG_W-2:0], 1'b0};
                    program_pin_out <= out_sr_q[`FTA_CFG_W-2];
                end
                PH_WRITE, PH_HYST, PH_IGNORE:
                begin
                    phase_q <= phase_q;
                end
                default:
                begin
                    phase_q <= PH_IGNORE;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Link side: events toward the core
    // ---------------------------------------------------------------
    // The hold word stays put for a whole frame, far longer than the core needs to take it.
    always_ff @(posedge serial_clock_pin or posedge srst)
    begin
        if (srst)
        begin
            hold_done_q <= 1'b0;
            hold_q <= '0;
        end
        else if (!chip_select_n && phase_q == PH_WRITE &&
                 bit_cnt_q == 6'(`FTA_CMD_W + `FTA_CFG_W - 1))
        begin
            hold_q <= {shift_q, serial_data_in};
            hold_done_q <= ~hold_done_q;
        end
    end

    always_ff @(posedge serial_clock_pin or posedge srst)
    begin
        if (srst)
        begin
            clear_tgl_q <= 1'b0;
            reload_tgl_q <= 1'b0;
        end
        else if (!chip_select_n && phase_q == PH_HYST && serial_data_in)
        begin
            if (bit_cnt_q == 6'(`FTA_CMD_W + 15 - `FTA_HYST_CLEAR_BIT))
            begin
                clear_tgl_q <= ~clear_tgl_q;
            end
            if (bit_cnt_q == 6'(`FTA_CMD_W + 15 - `FTA_HYST_RELOAD_BIT))
            begin
                reload_tgl_q <= ~reload_tgl_q;
            end
        end
    end

    // Snapshot copy; taken only while the link clock runs, so it may be a frame old.
    fta_sync #(.W(1)) u_req_sync
    (
        .clk(serial_clock_pin),
        .rst(srst),
        .din(req_tgl_q),
        .dout(req_l)
    );

    always_ff @(posedge serial_clock_pin or posedge srst)
    begin
        if (srst)
        begin
            ack_tgl_q <= 1'b0;
            copy_q <= '0;
        end
        else if (req_l != ack_tgl_q)
        begin
            ack_tgl_q <= req_l;
            copy_q <= snap_q;
        end
    end

    // ---------------------------------------------------------------
    // Core side: event capture
    // ---------------------------------------------------------------
    logic [3:0] link_s;
    logic done_prev_q;
    logic clear_prev_q;
    logic reload_prev_q;
    logic done_ev;
    logic clear_ev;
    logic reload_ev;
    logic ack_c;
    logic [4:0] hold_cmd;
    logic [15:0] cust_q;
    logic [`FTA_CFG_W-1:0] cfg_q;
    logic [15:0] eff;

    fta_sync #(.W(4)) u_core_sync
    (
        .clk(core_clk),
        .rst(srst),
        .din({hold_done_q, clear_tgl_q, reload_tgl_q, ack_tgl_q}),
        .dout(link_s)
    );

    assign ack_c = link_s[0];
    assign done_ev = link_s[3] != done_prev_q;
    assign clear_ev = link_s[2] != clear_prev_q;
    assign reload_ev = link_s[1] != reload_prev_q;
    assign hold_cmd = hold_q[50:46];
    assign eff = apply_redundancy(cfg_q[15:0]);

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            done_prev_q <= 1'b0;
            clear_prev_q <= 1'b0;
            reload_prev_q <= 1'b0;
        end
        else
        begin
            done_prev_q <= link_s[3];
            clear_prev_q <= link_s[2];
            reload_prev_q <= link_s[1];
        end
    end

    // ---------------------------------------------------------------
    // Core side: fuses and volatile configuration
    // ---------------------------------------------------------------
    // Fuses only ever gain set bits; a burn cannot undo an earlier one.
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            cust_q <= `FTA_CUST_RESET;
        end
        else if (done_ev && hold_cmd == `FTA_CMD_BURN)
        begin
            cust_q <= cust_q | hold_q[`FTA_CUST_MSB:0];
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            cfg_q <= '0;
            config_valid <= 1'b0;
        end
        else
        begin
            if (reload_ev)
            begin
                cfg_q <= {TRIM_INIT, cust_q};
                config_valid <= 1'b1;
            end
            if (done_ev && hold_cmd == `FTA_CMD_VOL_WRITE)
            begin
                cfg_q[`FTA_CUST_MSB:0] <= hold_q[`FTA_CUST_MSB:0];
            end
            if (done_ev && hold_cmd == `FTA_CMD_BURN)
            begin
                cfg_q[`FTA_CUST_MSB:0] <= cust_q | hold_q[`FTA_CUST_MSB:0];
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            zero_angle <= 8'h00;
            gain_setting <= 3'h0;
            polling_mode <= 1'b0;
        end
        else
        begin
            zero_angle <= eff[`FTA_ZERO_MSB:`FTA_ZERO_LSB];
            gain_setting <= eff[`FTA_GAIN_MSB:`FTA_GAIN_LSB];
            polling_mode <= eff[`FTA_POLL_BIT];
        end
    end

    // ---------------------------------------------------------------
    // Core side: revolution counter and lock
    // ---------------------------------------------------------------
    // A crossing in the clear cycle still counts, so no turn is lost to the clear.
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            revolution_count <= `FTA_COUNT_RESET;
        end
        else
        begin
            revolution_count <= (clear_ev ? `FTA_COUNT_RESET : revolution_count)
                + {7'h00, zero_cross_cw && !zero_cross_ccw}
                - {7'h00, zero_cross_ccw && !zero_cross_cw};
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            lock_status <= 1'b0;
        end
        else
        begin
            lock_status <= tracker_locked;
        end
    end

    // ---------------------------------------------------------------
    // Core side: snapshot toward the link
    // ---------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            snap_q <= '0;
            req_tgl_q <= 1'b0;
        end
        else if (ack_c == req_tgl_q)
        begin
            snap_q <= {lock_status, agc_value, angle_value, revolution_count,
                       config_valid ? cfg_q : {`FTA_CFG_W{1'b0}}};
            req_tgl_q <= ~req_tgl_q;
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    sequence s_clear_alone;
        clear_ev && !zero_cross_cw && !zero_cross_ccw;
    endsequence

    sequence s_cw_alone;
        !clear_ev && zero_cross_cw && !zero_cross_ccw;
    endsequence

    sequence s_ccw_alone;
        !clear_ev && zero_cross_ccw && !zero_cross_cw;
    endsequence

    // Set by a clear with no crossing, dropped by the next crossing
    logic since_clear_q;

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            since_clear_q <= 1'b0;
        end
        else if (clear_ev)
        begin
            since_clear_q <= !zero_cross_cw && !zero_cross_ccw;
        end
        else if (zero_cross_cw || zero_cross_ccw)
        begin
            since_clear_q <= 1'b0;
        end
    end

    a_count_clear: assert property (@(posedge core_clk) disable iff (srst)
        s_clear_alone |=> revolution_count == 8'h00)
        else $error("counter not cleared");
    a_count_up: assert property (@(posedge core_clk) disable iff (srst)
        s_cw_alone |=> revolution_count == $past(revolution_count) + 8'h01)
        else $error("counter did not increment");
    a_count_down: assert property (@(posedge core_clk) disable iff (srst)
        s_ccw_alone |=> revolution_count == $past(revolution_count) - 8'h01)
        else $error("counter did not decrement in two's complement");
    a_clear_then_count: assert property (@(posedge core_clk) disable iff (srst)
        since_clear_q ##0 s_cw_alone |=> revolution_count == 8'h01)
        else $error("crossing after clear lost");
    a_lock_follow: assert property (@(posedge core_clk) disable iff (srst)
        $rose(tracker_locked) |=> lock_status)
        else $error("lock not reported");
    a_snap_lock: assert property (@(posedge core_clk) disable iff (srst)
        ack_c == req_tgl_q |=> snap_q.lock == $past(lock_status))
        else $error("lock not taken into snapshot");
    a_trim_kept: assert property (@(posedge core_clk) disable iff (srst)
        !reload_ev |=> $stable(cfg_q[`FTA_CFG_W-1:`FTA_TRIM_LSB]))
        else $error("trim bits changed");
    a_vol_write: assert property (@(posedge core_clk) disable iff (srst)
        done_ev && hold_cmd == `FTA_CMD_VOL_WRITE
        |=> cfg_q[15:0] == $past(hold_q[15:0]) && $stable(cust_q))
        else $error("volatile write wrong or fuse changed");
    a_burn_sticky: assert property (@(posedge core_clk) disable iff (srst)
        done_ev && hold_cmd == `FTA_CMD_BURN |=> (cust_q & $past(hold_q[15:0])) == $past(hold_q[15:0]))
        else $error("burned bits missing");
    a_redund_high: assert property (@(posedge core_clk) disable iff (srst)
        ((cfg_q[15:0] & ~eff) == 16'h0000) && $countones(cfg_q[15:0] ^ eff) <= 1)
        else $error("redundancy forced low or several bits");
    a_poll_mode: assert property (@(posedge core_clk) disable iff (srst)
        ##1 polling_mode == $past(eff[`FTA_POLL_BIT]))
        else $error("polling mode does not follow config");
    a_analog_quiet: assert property (@(posedge serial_clock_pin) disable iff (frame_rst)
        !program_pin_oe_n |-> serial_data_oe_n)
        else $error("serial output driven in analog read");

endmodule

// ---- hdl/fta_defines.svh ----
// Command codes, field positions and reset values of the fuse access and turn counter
`ifndef FTA_DEFINES_SVH
`define FTA_DEFINES_SVH

// ---------------------------------------------------------------
// Frame geometry
// ---------------------------------------------------------------
`define FTA_CMD_W 5
`define FTA_CFG_W 46
`define FTA_EXT_BIT 3
`define FTA_RD_W 16

// ---------------------------------------------------------------
// Command codes
// ---------------------------------------------------------------
`define FTA_CMD_VOL_WRITE 5'h1f
`define FTA_CMD_BURN 5'h19
`define FTA_CMD_FUSE_READ 5'h0f
`define FTA_CMD_ANALOG_READ 5'h09
`define FTA_CMD_HYST_RESET 5'h13
`define FTA_CMD_ANGLE_READ 5'h00
`define FTA_CMD_COUNT_READ 5'h01

// ---------------------------------------------------------------
// Configuration fields
// ---------------------------------------------------------------
`define FTA_ZERO_MSB 7
`define FTA_ZERO_LSB 0
`define FTA_POLL_BIT 8
`define FTA_GAIN_MSB 11
`define FTA_GAIN_LSB 9
`define FTA_RED_MSB 15
`define FTA_RED_LSB 12
`define FTA_CUST_MSB 15
`define FTA_TRIM_LSB 16
`define FTA_RED_FIRST 4'h1
`define FTA_RED_LAST 4'hc

// ---------------------------------------------------------------
// Hysteresis/reset payload bits and reset values
// ---------------------------------------------------------------
`define FTA_HYST_RELOAD_BIT 15
`define FTA_HYST_CLEAR_BIT 13
`define FTA_COUNT_RESET 8'h00
`define FTA_CUST_RESET 16'h0000

`endif

// ---- hdl/fta_pkg.sv ----
// Types shared by the fuse access and turn counter
package fta_pkg;

    // Link frame phases
    typedef enum logic [2:0]
    {
        PH_CMD,
        PH_READ,
        PH_ANALOG,
        PH_WRITE,
        PH_HYST,
        PH_IGNORE
    } fta_phase_t;

    // Core state image handed to the serial side
    typedef struct packed
    {
        logic lock;
        logic [5:0] agc;
        logic [7:0] angle;
        logic [7:0] count;
        logic [45:0] cfg;
    } fta_snap_t;

endpackage

// ---- hdl/fta_sync.sv ----
// Two flip-flop level synchroniser
`timescale 1ns/1ps
module fta_sync
#(
    parameter int W = 1
)
(
    // Destination clock and reset
    input wire logic clk,
    input wire logic rst,
    // Levels
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);

    logic [W-1:0] meta_q;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            meta_q <= '0;
            dout <= '0;
        end
        else
        begin
            meta_q <= din;
            dout <= meta_q;
        end
    end

endmodule

// ---- sim/fta_host_model.sv ----
// Host model that frames commands on the serial link
`timescale 1ns/1ps
module fta_host_model
(
    // Link drive
    output logic sclk,
    output logic cs_n,
    output logic sdi,
    // Device answers
    input wire logic sdo,
    input wire logic sdo_oe_n,
    input wire logic pgm,
    // Serial drive seen in last frame
    output logic oe_seen
);
    initial
    begin
        // Select starts low so that the rise of reset gives the frame logic a clean edge
        sclk = 1'b0;
        cs_n = 1'b0;
        sdi = 1'b0;
        oe_seen = 1'b0;
        #2 cs_n = 1'b1;
    end

    // Clock only runs inside a frame; answers sampled on the falling edge
    task automatic frame(input logic [4:0] c, input int n, input logic [45:0] w,
        output logic [45:0] rd, output logic [45:0] an);
        logic [50:0] bits;
        bits = {c, w << (46 - n)};
        rd = '0;
        an = '0;
        oe_seen = 1'b0;
        #37 cs_n = 1'b0;
        for (int i = 0; i < 5 + n; i++)
        begin
            sdi = bits[50 - i];
            #62.5 sclk = 1'b1;
            #62.5 sclk = 1'b0;
            if (i >= 4 && i < 4 + n)
            begin
                // A released output reads as the inverse of its last value
                rd = {rd[44:0], sdo_oe_n ? ~sdo : sdo};
                an = {an[44:0], pgm};
            end
            if (!sdo_oe_n)
                oe_seen = 1'b1;
        end
        #62.5 cs_n = 1'b1;
        // Released line must not keep its last value
        sdi = ~sdi;
    endtask
endmodule

// ---- sim/tb_fuse_access_and_turn_counter.sv ----
// Testbench of the fuse access and turn counter
`timescale 1ns/1ps
`define CHK(g, e, m) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("unexpected t=%0t %s", $time, m); end end
module tb_fuse_access_and_turn_counter;
    import fta_pkg::*;
    localparam logic [29:0] TRIM = 30'h2a5a5a5a;
    logic core_clk = 1'b0;
    logic srst = 1'b0;
    logic locked = 1'b0;
    logic cw = 1'b0;
    logic ccw = 1'b0;
    logic [5:0] agc = 6'h15;
    logic [7:0] ang = 8'h3c;
    logic sclk, cs_n, sdi, sdo, sdo_oe_n, pgm, pgm_oe_n, oe_seen, lock_st, cfg_ok, poll;
    logic [7:0] zero, cnt;
    logic [2:0] gain;
    logic [45:0] rd, ana, base;
    logic [15:0] e16;
    int n_mismatch = 0;
    int check_count = 0;
    int cycles = 0;
    int pgm_edges = 0;

    always #50 core_clk = ~core_clk;

    // Link clocks that see the program pin driven
    always @(negedge sclk)
    begin
        if (pgm_oe_n === 1'b0)
            pgm_edges++;
    end

    fta_host_model host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo),
        .sdo_oe_n(sdo_oe_n), .pgm(pgm), .oe_seen(oe_seen));

    fta_fuse_turn #(.TRIM_INIT(TRIM)) uut (.core_clk(core_clk), .srst(srst),
        .serial_clock_pin(sclk), .chip_select_n(cs_n), .serial_data_in(sdi),
        .serial_data_out(sdo), .serial_data_oe_n(sdo_oe_n), .program_pin_in(1'b0),
        .program_pin_out(pgm), .program_pin_oe_n(pgm_oe_n), .tracker_locked(locked),
        .angle_value(ang), .agc_value(agc), .zero_cross_cw(cw), .zero_cross_ccw(ccw),
        .zero_angle(zero), .gain_setting(gain), .polling_mode(poll),
        .revolution_count(cnt), .lock_status(lock_st), .config_valid(cfg_ok));

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Whole run needs about 2200 core cycles
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            conclude();
        end
    end

    // One frame, then room for the domain crossing to settle
    task automatic link(input logic [4:0] c, input int n, input logic [45:0] w);
        host.frame(c, n, w, rd, ana);
        repeat (6) @(posedge core_clk);
        #1;
    endtask

    // Snapshot may be a frame old, so the second read counts
    task automatic rd2(input logic [4:0] c, input int n);
        link(c, n, '0);
        link(c, n, '0);
    endtask

    task automatic pulse(input logic up, input int k);
        repeat (k)
        begin
            cw = up;
            ccw = ~up;
            @(posedge core_clk);
            #1;
            cw = 1'b0;
            ccw = 1'b0;
            @(posedge core_clk);
            #1;
        end
    endtask

    initial
    begin
        #1 srst = 1'b1;
        repeat (4) @(posedge core_clk);
        #1 srst = 1'b0;
        `CHK(cnt, 8'h00, "count after reset")
        `CHK(sdo_oe_n, 1'b1, "serial not released")
        repeat (4) @(posedge core_clk);
        #1;
        link(5'h13, 16, 46'h8000);
        `CHK(cfg_ok, 1'b1, "no reload")
        $display("test reset and reload done");
        link(5'h1f, 46, {~TRIM, 16'h0b5c});
        `CHK(zero, 8'h5c, "zero angle")
        `CHK(gain, 3'h5, "gain")
        `CHK(poll, 1'b1, "polling")
        rd2(5'h0f, 46);
        `CHK(rd, {TRIM, 16'h0b5c}, "config read")
        for (int s = 0; s < 16; s++)
        begin
            base = '0;
            if (s >= 1 && s <= 12)
                base[s - 1] = 1'b1;
            link(5'h1f, 46, {TRIM, s[3:0], 12'h000});
            `CHK({poll, gain, zero}, {base[8], base[11:9], base[7:0]}, "redundancy")
        end
        $display("test write and redundancy done");
        link(5'h19, 46, {~TRIM, 16'h1234});
        link(5'h1f, 46, {TRIM, 16'h0000});
        link(5'h13, 16, 46'h8000);
        rd2(5'h0f, 46);
        `CHK(rd, {TRIM, 16'h1234}, "burned bits")
        `CHK(zero, 8'h35, "forced bit")
        link(5'h09, 46, '0);
        `CHK(ana, {TRIM, 16'h1234}, "analog stream")
        `CHK(oe_seen, 1'b0, "serial driven")
        // Pin driven from the code's last edge to the end of the 51-edge frame
        `CHK(pgm_edges, 47, "program pin drive")
        $display("test burn and analog read done");
        locked = 1'b1;
        pulse(1'b1, 3);
        pulse(1'b0, 5);
        `CHK(cnt, 8'hfe, "count")
        pulse(1'b1, 129);
        `CHK(cnt, 8'h7f, "count top")
        pulse(1'b1, 1);
        `CHK(cnt, 8'h80, "count wrap")
        `CHK(lock_st, 1'b1, "lock")
        rd2(5'h01, 16);
        e16 = {1'b1, agc, 8'h80, 1'b0};
        e16[0] = ^e16[15:1];
        `CHK(rd[15:0], e16, "count read")
        link(5'h13, 16, 46'h2000);
        `CHK(cnt, 8'h00, "clear")
        pulse(1'b1, 1);
        `CHK(cnt, 8'h01, "after clear")
        locked = 1'b0;
        rd2(5'h00, 16);
        e16 = {1'b0, agc, ang, 1'b0};
        e16[0] = ^e16[15:1];
        `CHK(lock_st, 1'b0, "unlock")
        `CHK(rd[15:0], e16, "angle read")
        $display("test counter and lock done");
        conclude();
    end
endmodule
